// File: hdl/ipsmp_pkg.sv
// package: constants and carrier types for the isochronous position sampler
package ipsmp_pkg;

  // raw position width: 28-bit total resolution range
  localparam int unsigned POS_W = 28;
  // signed speed width
  localparam int unsigned SPD_W = 32;
  // application cycle factor width
  localparam int unsigned RATIO_W = 8;
  // scaling multiplier width (q16 fixed point)
  localparam int unsigned SCALE_W = 18;
  localparam int unsigned SCALE_FRAC = 16;

  // reset values
  localparam logic [RATIO_W-1:0] RATIO_RST = 8'h01;
  localparam logic [SCALE_W-1:0] SCALE_RST = 18'h10000;
  localparam logic [POS_W-1:0] POS_RST = 28'h0000000;

  // processing pipeline length in cycles after capture
  localparam int unsigned PROC_CYCLES = 2;

  // processed sample carried from processing to the hand-off register and out
  typedef struct packed {
    logic [POS_W-1:0] position;
    logic [SPD_W-1:0] speed;
  } ipsmp_sample_type;

  // acquisition sequencing
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SCALE,
    ST_SPEED
  } ipsmp_state_type;

endpackage : ipsmp_pkg

// File: hdl/ipsmp_sync.sv
// module: two-flop synchroniser with rising-edge pulse for the isochronous tick
`timescale 1ns/1ns
module ipsmp_sync (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_async, // asynchronous level from the pin
  output logic o_level, // synchronised level
  output logic o_rise // one-cycle pulse on a rising edge
);
  import ipsmp_pkg::*;

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first flop feeds only the second one
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;

endmodule : ipsmp_sync

// File: hdl/ipsmp_top.sv
// module: isochronous position sampler, tick-paced acquisition to network hand-off
`timescale 1ns/1ns
module ipsmp_top (
  input wire logic i_clk_sys, // system clock, 10 MHz
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_iso_tick, // isochronous clock from the network, async pin
  input wire logic [ipsmp_pkg::POS_W-1:0] i_raw_pos, // raw position from the sensing front end
  input wire logic [ipsmp_pkg::RATIO_W-1:0] i_app_to_iso_cycle_ratio, // application cycle factor
  input wire logic [ipsmp_pkg::SCALE_W-1:0] i_scale, // position scaling, q16
  output ipsmp_pkg::ipsmp_sample_type o_tx_sample, // sample handed to the network
  output logic o_tx_valid, // one-cycle pulse: send o_tx_sample
  output logic o_buf_full, // buffer currently holds an unsent value
  output logic o_overwrite // one-cycle pulse: unsent sample was discarded
);
  import ipsmp_pkg::*;

  // tick edge from the synchroniser
  logic tick_rise;

  // acquisition and processing
  ipsmp_state_type state_q;
  logic [POS_W-1:0] raw_q;
  logic [POS_W-1:0] scaled_q;
  logic [POS_W-1:0] last_pos_q;
  logic signed [POS_W:0] pos_diff;
  logic [SPD_W-1:0] speed_d;
  logic [POS_W+SCALE_W-1:0] product;
  logic first_q;
  ipsmp_sample_type proc_sample;

  // application cycle and buffer
  logic [RATIO_W-1:0] ratio_q;
  logic [RATIO_W-1:0] tick_cnt_q;
  logic app_read;
  logic buf_write;
  logic buf_full_q;
  logic overwrite_q;

  // hand-off registers
  ipsmp_sample_type tx_q;
  logic tx_valid_q;

  // tick pin crosses into the system clock before any use
  // only the rise is used; the synchronised level stays open
  ipsmp_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_iso_tick),
    .o_level(),
    .o_rise(tick_rise)
  );

  // capture and processing sequence, started only by the tick
  // there is no local timer that could drift away from the network tick
  // a tick in the scaling cycle is lost, so ticks closer than two clocks collapse
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      raw_q <= POS_RST;
      scaled_q <= POS_RST;
    end else begin
      case (state_q)
        // idle: wait for the next tick
        ST_IDLE: begin
          if (tick_rise) begin
            raw_q <= i_raw_pos;
            state_q <= ST_SCALE;
          end
        end
        // scaling cycle: tick edges here are not taken
        ST_SCALE: begin
          scaled_q <= product[SCALE_FRAC +: POS_W];
          state_q <= ST_SPEED;
        end
        ST_SPEED: begin
          // a tick in the speed cycle restarts capture so that tick is not lost
          if (tick_rise) begin
            raw_q <= i_raw_pos;
            state_q <= ST_SCALE;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // scaling product; the fraction bits are dropped on purpose
  // product bits above the position range are lost as well, so a scale above
  // one wraps large positions
  assign product = raw_q * i_scale;

  // speed as the signed position change over one isochronous cycle; the difference
  // is taken over the full range, so a position wrap shows as a large jump
  always_comb begin
    pos_diff = signed'({1'b0, scaled_q}) - signed'({1'b0, last_pos_q});
    speed_d = SPD_W'(pos_diff);
  end

  // the buffer is written in the last processing cycle
  assign buf_write = (state_q == ST_SPEED);

  // remember previous position for the next speed figure
  // the first sample only seeds it and reports zero speed
  // later samples take their difference to it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      last_pos_q <= POS_RST;
      first_q <= 1'b1;
    end else if (buf_write) begin
      last_pos_q <= scaled_q;
      first_q <= 1'b0;
    end
  end

  // application cycle counter in isochronous ticks; factor 0 treated as 1
  // every tick counts, including one that restarts processing
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_cnt_q <= '0;
      ratio_q <= RATIO_RST;
    end else if (tick_rise) begin
      if (tick_cnt_q + 8'h01 >= ratio_q || ratio_q == '0) begin
        tick_cnt_q <= '0;
        // factor changes take effect only at an application cycle boundary
        ratio_q <= (i_app_to_iso_cycle_ratio == '0) ? RATIO_RST : i_app_to_iso_cycle_ratio;
      end else begin
        tick_cnt_q <= tick_cnt_q + 8'h01;
      end
    end
  end

  // read once per application cycle, in the tick that closes it
  // the read happens after processing of that tick so the sent value is fresh
  // a tick in the speed cycle re-arms the flag for its own sample only
  logic app_due_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      app_due_q <= 1'b0;
    end else if (tick_rise) begin
      app_due_q <= (tick_cnt_q + 8'h01 >= ratio_q) || (ratio_q == '0);
    end else if (buf_write) begin
      app_due_q <= 1'b0;
    end
  end
  assign app_read = buf_write & app_due_q;

  // single buffer slot: it fills with every processed sample that is not sent at once
  // and empties when the application cycle read takes the sample out; no data is
  // kept, since a buffered sample can only leave in the tick that replaces it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      buf_full_q <= 1'b0;
    end else if (app_read) begin
      buf_full_q <= 1'b0;
    end else if (buf_write) begin
      buf_full_q <= 1'b1;
    end
  end

  // discard pulse: a buffered sample that never left is replaced by a newer one,
  // on a sending tick as well, because the send takes the newer sample
  // the pulse lasts one cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      overwrite_q <= 1'b0;
    end else begin
      overwrite_q <= buf_write & buf_full_q;
    end
  end

  // processed sample as it stands in its last processing cycle; the first
  // sample has no predecessor, so its speed reads as zero
  always_comb begin
    proc_sample = '0;
    proc_sample.position = scaled_q;
    if (!first_q) begin
      proc_sample.speed = speed_d;
    end
  end

  // send strobe: one cycle for each application cycle read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= app_read;
    end
  end

  // sent sample: the one taken in the tick that closes the application cycle,
  // never an older one; it stands until the next send
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_q <= '0;
    end else if (app_read) begin
      tx_q <= proc_sample;
    end
  end

  // every output comes straight from a register, so the network side sees
  // no combinational path from the tick pin
  assign o_tx_sample = tx_q;
  assign o_tx_valid = tx_valid_q;
  assign o_buf_full = buf_full_q;
  assign o_overwrite = overwrite_q;

endmodule : ipsmp_top

// File: tb/ipsmp_chk.sv
// checker: port timing of the position sampler
`timescale 1ns/1ns
module ipsmp_chk (
  input wire logic i_clk_sys, // clock
  input wire logic i_rst, // reset
  input wire logic i_iso_tick, // tick pin
  input ipsmp_pkg::ipsmp_sample_type o_tx_sample, // sent sample
  input wire logic o_tx_valid, // send pulse
  input wire logic o_buf_full, // buffer level
  input wire logic o_overwrite // discard pulse
);
  logic tick_q;
  logic [3:0] since_q;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // last pin level, for edge detection
  always_ff @(posedge i_clk_sys) begin
    tick_q <= i_iso_tick;
  end
  // edges since a tick; saturates so a stale tick never looks fresh
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) since_q <= 4'hF;
    else if (i_iso_tick && !tick_q) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  a_tick_paced: assert property (o_tx_valid |-> since_q inside {[4'h3:4'h7]})
    else $error("send far from tick");
  a_tick_answer: assert property ($rose(i_iso_tick) |-> ##[3:8] (o_tx_valid || o_overwrite || $rose(o_buf_full)))
    else $error("tick unanswered");
  a_tx_single: assert property (o_tx_valid |=> !o_tx_valid)
    else $error("double send");
  a_tx_empties: assert property (o_tx_valid |-> !o_buf_full && (o_overwrite == $past(o_buf_full)))
    else $error("send left buffer full");
  a_ovw_when_full: assert property (o_overwrite |-> $past(o_buf_full) && (o_buf_full || o_tx_valid))
    else $error("discard of empty buffer");
  a_ovw_single: assert property (o_overwrite |=> !o_overwrite)
    else $error("double discard");
  a_sample_holds: assert property (!o_tx_valid |-> $stable(o_tx_sample))
    else $error("sample moved");
  a_drain_on_send: assert property ($fell(o_buf_full) |-> o_tx_valid)
    else $error("buffer drained unsent");
  c_send: cover property (o_tx_valid);
  c_ovw: cover property (o_overwrite);
  c_held: cover property (o_buf_full ##1 o_tx_valid);
endmodule : ipsmp_chk

// File: tb/ipsmp_ctrl.sv
// partner: network controller making the isochronous tick
`timescale 1ns/1ns
module ipsmp_ctrl (
  output logic o_iso_tick // one tick shared by all nodes
);
  // own timer, unrelated in phase to the device clock
  initial begin
    o_iso_tick = 1'b0;
    forever begin
      #1237 o_iso_tick = 1'b1;
      #300 o_iso_tick = 1'b0;
    end
  end
endmodule : ipsmp_ctrl

// File: tb/ipsmp_top_tb.sv
// testbench: sampler against a tick-by-tick model
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module ipsmp_top_tb;
  import ipsmp_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic tick;
  logic [POS_W-1:0] raw = '0;
  logic [SCALE_W-1:0] scale = SCALE_RST;
  logic [RATIO_W-1:0] ratio = RATIO_RST;
  ipsmp_sample_type tx_sample;
  logic tx_valid;
  logic buf_full;
  logic ovw;
  int fail_count = 0;
  int check_count = 0;
  int cnt = 0;
  int act = 1;
  bit full_m = 0;
  bit first = 1;
  logic [POS_W-1:0] prev;
  int rt[5] = '{1, 2, 3, 0, 4};
  always #50 i_clk_sys = ~i_clk_sys;
  ipsmp_ctrl ctrl (.o_iso_tick(tick));
  ipsmp_top dut (.i_clk_sys, .i_rst, .i_iso_tick(tick), .i_raw_pos(raw), .i_app_to_iso_cycle_ratio(ratio),
    .i_scale(scale), .o_tx_sample(tx_sample), .o_tx_valid(tx_valid), .o_buf_full(buf_full), .o_overwrite(ovw));
  // one tick: fresh raw and scale, model the buffer, then watch the send window
  task automatic step(output bit sent);
    logic [POS_W-1:0] sc;
    int d;
    ipsmp_sample_type exp;
    ipsmp_sample_type got;
    int nt = 0;
    int no = 0;
    @(posedge tick);
    @(posedge i_clk_sys);
    #1;
    raw = POS_W'($urandom);
    scale = SCALE_W'($urandom);
    sc = POS_W'((64'(raw) * 64'(scale)) >> SCALE_FRAC);
    d = first ? 0 : int'(sc) - int'(prev);
    exp = '{sc, SPD_W'(d)};
    prev = sc;
    first = 0;
    cnt++;
    sent = cnt >= act;
    // factor is adopted at the boundary; zero acts as one
    if (sent) begin
      cnt = 0;
      act = (ratio == 0) ? 1 : ratio;
    end
    repeat (10) begin
      @(posedge i_clk_sys);
      #1;
      if (tx_valid !== 1'b0) begin nt++; got = tx_sample; end
      if (ovw !== 1'b0) no++;
    end
    `CHK("sends", sent ? 1 : 0, nt)
    if (sent) `CHK("sample", exp, got)
    `CHK("discard", full_m ? 1 : 0, no)
    `CHK("full", !sent, buf_full)
    full_m = !sent;
  endtask : step
  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // each factor runs three application cycles; changes land between ticks
  initial begin
    bit s;
    int n;
    void'($urandom(19));
    repeat (10) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    foreach (rt[i]) begin
      ratio = RATIO_W'(rt[i]);
      n = 0;
      while (n < 3) begin step(s); n += s; end
    end
    test_done();
  end
  // bounded run: about six times the expected length
  initial begin
    #300000;
    fail_count++;
    test_done();
  end
endmodule : ipsmp_top_tb
bind ipsmp_top ipsmp_chk chk (.i_clk_sys, .i_rst, .i_iso_tick, .o_tx_sample, .o_tx_valid, .o_buf_full, .o_overwrite);
